// File: lcc_cluster.sv
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
// How it works
// - ten cells with carry, shared controls, local routing, lut and reg chains
// - local plus direct-link inputs let each cell reach thirty cells
// - control generator gives at most ten cluster-wide controls
// - each cluster clock is tied to its own clock enable
// - rising and falling clocking use both clock resources, one per edge
// - enable low gates the cluster clock, registers hold
// - async load with load data high acts as a preset to one
// - controls come from eight row clocks and local routing lines
// - each cell has a four-input table computing any function
// - cell register works as D, T, JK or SR flip-flop
// - register has data, load data, clock, enable, clear, load inputs
// - async load data is the cell's fourth table input
// - combinational use bypasses the register, table drives outputs
// - three outputs each pick table result or register output
// - two outputs go to row and direct link, one to local routing
// - packing feeds register output back into its own table
// - table result passes to the next cell for wide functions
// - register output feeds next cell register as shift chain
// - add/subtract select picks A plus B or A minus B
// - subtraction inverts every B bit and forces carry-in to one
// - first cell holds the LSB, its carry-in comes from the select
// - register clock and clear each pick one of two cluster-wide controls
// - async clear wins over async preset/load, output goes zero
// - enabled device-wide reset clears every register above all else
module lcc_cluster (
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_B_I,
   // avalon-mm slave
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // fabric inputs
   input wire logic [lcc_pkg::NROW-1:0] ROW_CLOCK_I,
   input wire logic [lcc_pkg::NLOCAL-1:0] LOCAL_CTRL_I,
   input wire logic [lcc_pkg::NDIRECT-1:0] DIRECT_LINK_I,
   input wire logic [lcc_pkg::NROUTE-1:0] ROUTE_I,
   input wire logic DEVICE_WIDE_RESET_N_I,
   // cell outputs
   output logic [lcc_pkg::NCELL-1:0] CELL_ROUTE_A_O,
   output logic [lcc_pkg::NCELL-1:0] CELL_ROUTE_B_O,
   output logic [lcc_pkg::NCELL-1:0] CELL_LOCAL_O,
   // chain outputs
   output logic LUT_CHAIN_O,
   output logic REG_CHAIN_O,
   output logic CARRY_OUT_O
);

   localparam int unsigned EXT_W = lcc_pkg::NDIRECT + lcc_pkg::NROUTE;
   localparam int unsigned POOL_W = lcc_pkg::NROW + lcc_pkg::NLOCAL;
   localparam int unsigned PAD_W = lcc_pkg::NSRC - EXT_W - lcc_pkg::NCELL;

   typedef struct packed {
      logic [lcc_pkg::NCELL-1:0][lcc_pkg::CFG_W-1:0] cell_cfg;
      logic [lcc_pkg::NCELL-1:0][4*lcc_pkg::SEL_W-1:0] cell_sel;
      logic [31:0] ctrl_lo;
      logic [lcc_pkg::HI_W-1:0] ctrl_hi;
      logic [POOL_W-1:0] pool_s1;
      logic [POOL_W-1:0] pool_s2;
      logic [EXT_W-1:0] ext_s1;
      logic [EXT_W-1:0] ext_s2;
      logic rst_s1;
      logic rst_s2;
      logic [1:0] clk_prev;
      logic [lcc_pkg::NCELL-1:0] q;
      logic [lcc_pkg::NCELL-1:0] out_a;
      logic [lcc_pkg::NCELL-1:0] out_b;
      logic [lcc_pkg::NCELL-1:0] out_loc;
      logic lut_chain;
      logic carry_out;
      logic wait_req;
      logic [31:0] rdata;
   } lcc_state_t;

   lcc_state_t s;
   lcc_state_t next_s;

   function automatic logic lut4(input logic [15:0] mask,
                                 input logic [3:0] sel);
      return mask[sel];
   endfunction : lut4

   function automatic logic pick_ctl(input logic [3:0] src,
                                     input logic use_it,
                                     input logic dflt,
                                     input logic [POOL_W-1:0] pool);
      return use_it ? pool[src] : dflt;
   endfunction : pick_ctl

   function automatic logic edge_seen(input logic prev, input logic now,
                                      input logic fall);
      return fall ? (prev & ~now) : (~prev & now);
   endfunction : edge_seen

   function automatic logic ff_next(input logic [1:0] kind,
                                    input logic q, input logic x,
                                    input logic y);
      logic r;
      r = q;
      unique case (kind)
         lcc_pkg::LCC_FF_D: r = x;
         lcc_pkg::LCC_FF_T: r = q ^ x;
         lcc_pkg::LCC_FF_JK: r = x ? (y ? ~q : 1'b1) : (y ? 1'b0 : q);
         lcc_pkg::LCC_FF_SR: r = y ? 1'b0 : (x ? 1'b1 : q);
      endcase
      return r;
   endfunction : ff_next

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int k = 0; k < 4; k++) begin
         if (be[k]) begin
            r[8*k +: 8] = wd[8*k +: 8];
         end
      end
      return r;
   endfunction : be_merge

   always_comb begin
      logic [lcc_pkg::NSRC-1:0] src;
      logic [39:0] ctl_src;
      logic [lcc_pkg::NCTRL-1:0] ctl;
      logic [1:0] lvl;
      logic [1:0] tick;
      logic [3:0] lin;
      logic [lcc_pkg::CFG_W-1:0] cfg;
      logic [4*lcc_pkg::SEL_W-1:0] selw;
      logic lut_prev;
      logic q_prev;
      logic carry;
      logic a;
      logic b;
      logic bb;
      logic c;
      logic d;
      logic res;
      logic dsrc;
      logic nq;
      logic clr;
      logic [7:0] addr;
      logic [31:0] rd;
      src = '0;
      ctl_src = '0;
      ctl = '0;
      lvl = '0;
      tick = '0;
      lin = '0;
      cfg = '0;
      selw = '0;
      lut_prev = 1'b0;
      q_prev = 1'b0;
      carry = 1'b0;
      a = 1'b0;
      b = 1'b0;
      bb = 1'b0;
      c = 1'b0;
      d = 1'b0;
      res = 1'b0;
      dsrc = 1'b0;
      nq = 1'b0;
      clr = 1'b0;
      addr = {AVS_ADDRESS_I[7:2], 2'b00};
      rd = '0;
      next_s = s;

      // two-stage synchronisers on every fabric input
      next_s.pool_s1 = {LOCAL_CTRL_I, ROW_CLOCK_I};
      next_s.pool_s2 = s.pool_s1;
      next_s.ext_s1 = {ROUTE_I, DIRECT_LINK_I};
      next_s.ext_s2 = s.ext_s1;
      next_s.rst_s1 = DEVICE_WIDE_RESET_N_I;
      next_s.rst_s2 = s.rst_s1;

      // control generator
      ctl_src = {s.ctrl_hi[7:0], s.ctrl_lo};
      for (int k = 0; k < lcc_pkg::NCTRL; k++) begin
         ctl[k] = pick_ctl(ctl_src[4*k +: 4],
                           s.ctrl_hi[lcc_pkg::USE_LSB + k],
                           (k == lcc_pkg::CTL_ENA_A) ||
                           (k == lcc_pkg::CTL_ENA_B),
                           s.pool_s2);
      end
      lvl = {ctl[lcc_pkg::CTL_CLK_B], ctl[lcc_pkg::CTL_CLK_A]};
      next_s.clk_prev = lvl;
      for (int j = 0; j < 2; j++) begin
         tick[j] = edge_seen(s.clk_prev[j], lvl[j],
                             s.ctrl_hi[lcc_pkg::FALL_LSB + j])
                   & ctl[lcc_pkg::CTL_ENA_A + j];
      end

      // cell input pool: local outs, direct link, row/column routing
      src = {{PAD_W{1'b0}}, s.ext_s2, s.out_loc};
      carry = ctl[lcc_pkg::CTL_ADDSUB];
      for (int i = 0; i < lcc_pkg::NCELL; i++) begin
         cfg = s.cell_cfg[i];
         selw = s.cell_sel[i];
         for (int m = 0; m < 4; m++) begin
            lin[m] = src[selw[lcc_pkg::SEL_W*m +: lcc_pkg::SEL_W]];
         end
         a = cfg[lcc_pkg::LUT_CHAIN_BIT] ? lut_prev : lin[0];
         b = cfg[lcc_pkg::PACK_BIT] ? s.q[i] : lin[1];
         c = lin[2];
         d = lin[3];
         if (cfg[lcc_pkg::ARITH_BIT]) begin
            bb = b ^ ctl[lcc_pkg::CTL_ADDSUB];
            res = a ^ bb ^ carry;
            carry = (a & bb) | (a & carry) | (bb & carry);
         end else begin
            res = lut4(cfg[lcc_pkg::LUT_MASK_LSB +: 16],
                       {d, c, b, a});
         end
         dsrc = cfg[lcc_pkg::REG_CHAIN_BIT] ? q_prev : res;
         nq = s.q[i];
         if (cfg[lcc_pkg::CLK_SEL_BIT] ? tick[1] : tick[0]) begin
            if (ctl[lcc_pkg::CTL_SCLR]) begin
               nq = 1'b0;
            end else if (ctl[lcc_pkg::CTL_SLOAD]) begin
               nq = d;
            end else begin
               nq = ff_next(cfg[lcc_pkg::FF_TYPE_LSB +: 2],
                            s.q[i], dsrc, d);
            end
         end
         clr = cfg[lcc_pkg::CLR_SEL_BIT] ? ctl[lcc_pkg::CTL_CLR_B]
                                         : ctl[lcc_pkg::CTL_CLR_A];
         if (clr) begin
            nq = 1'b0;
         end else if (ctl[lcc_pkg::CTL_ALOAD]) begin
            nq = d;
         end
         if (s.ctrl_hi[lcc_pkg::DEV_RST_EN_BIT] && !s.rst_s2) begin
            nq = 1'b0;
         end
         next_s.q[i] = nq;
         // output selection per port, table result when bit low
         next_s.out_a[i] = cfg[lcc_pkg::OUT_SEL_LSB] ? nq : res;
         next_s.out_b[i] = cfg[lcc_pkg::OUT_SEL_LSB + 1] ? nq : res;
         next_s.out_loc[i] = cfg[lcc_pkg::OUT_SEL_LSB + 2] ? nq : res;
         lut_prev = res;
         q_prev = s.q[i];
      end
      next_s.lut_chain = lut_prev;
      next_s.carry_out = carry;

      // register bus: answer one cycle after the request appears
      for (int i = 0; i < lcc_pkg::NCELL; i++) begin
         if (addr == 8'(lcc_pkg::CELL_CFG_OFS + 8'(4*i))) begin
            rd = 32'(s.cell_cfg[i]);
         end
         if (addr == 8'(lcc_pkg::CELL_SEL_OFS + 8'(4*i))) begin
            rd = 32'(s.cell_sel[i]);
         end
      end
      if (addr == lcc_pkg::CTRL_SRC_LO_OFS) begin
         rd = s.ctrl_lo;
      end
      if (addr == lcc_pkg::CTRL_SRC_HI_OFS) begin
         rd = 32'(s.ctrl_hi);
      end
      if (addr == lcc_pkg::STATUS_OFS) begin
         rd = {21'h000000, s.carry_out, s.q};
      end

      if (s.wait_req) begin
         if (AVS_READ_I || AVS_WRITE_I) begin
            next_s.wait_req = 1'b0;
            if (AVS_READ_I) begin
               next_s.rdata = rd;
            end
         end
      end else begin
         next_s.wait_req = 1'b1;
         if (AVS_WRITE_I) begin
            for (int i = 0; i < lcc_pkg::NCELL; i++) begin
               if (addr == 8'(lcc_pkg::CELL_CFG_OFS + 8'(4*i))) begin
                  next_s.cell_cfg[i] = lcc_pkg::CFG_W'(be_merge(
                     32'(s.cell_cfg[i]), AVS_WRITEDATA_I,
                     AVS_BYTEENABLE_I));
               end
               if (addr == 8'(lcc_pkg::CELL_SEL_OFS + 8'(4*i))) begin
                  next_s.cell_sel[i] = (4*lcc_pkg::SEL_W)'(be_merge(
                     32'(s.cell_sel[i]), AVS_WRITEDATA_I,
                     AVS_BYTEENABLE_I));
               end
            end
            if (addr == lcc_pkg::CTRL_SRC_LO_OFS) begin
               next_s.ctrl_lo = be_merge(s.ctrl_lo, AVS_WRITEDATA_I,
                                         AVS_BYTEENABLE_I);
            end
            if (addr == lcc_pkg::CTRL_SRC_HI_OFS) begin
               next_s.ctrl_hi = lcc_pkg::HI_W'(be_merge(
                  32'(s.ctrl_hi), AVS_WRITEDATA_I, AVS_BYTEENABLE_I));
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_B_I) begin
         s <= '0;
         s.cell_cfg <= {lcc_pkg::NCELL{lcc_pkg::CELL_CFG_RST}};
         s.cell_sel <= {lcc_pkg::NCELL{lcc_pkg::CELL_SEL_RST}};
         s.ctrl_lo <= lcc_pkg::CTRL_SRC_LO_RST;
         s.ctrl_hi <= lcc_pkg::CTRL_SRC_HI_RST;
         s.wait_req <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign AVS_READDATA_O = s.rdata;
   assign AVS_WAITREQUEST_O = s.wait_req;
   assign CELL_ROUTE_A_O = s.out_a;
   assign CELL_ROUTE_B_O = s.out_b;
   assign CELL_LOCAL_O = s.out_loc;
   assign LUT_CHAIN_O = s.lut_chain;
   assign REG_CHAIN_O = s.q[lcc_pkg::NCELL-1];
   assign CARRY_OUT_O = s.carry_out;

endmodule : lcc_cluster

// File: lcc_pkg.sv
package lcc_pkg;

   // cluster geometry
   localparam int unsigned NCELL = 10;
   localparam int unsigned NROW = 8;
   localparam int unsigned NLOCAL = 8;
   localparam int unsigned NDIRECT = 20;
   localparam int unsigned NROUTE = 16;
   localparam int unsigned NCTRL = 10;
   localparam int unsigned SEL_W = 6;
   localparam int unsigned NSRC = 64;
   localparam int unsigned CFG_W = 27;
   localparam int unsigned HI_W = 21;

   // register byte offsets
   localparam logic [7:0] CELL_CFG_OFS = 8'h00;
   localparam logic [7:0] CELL_SEL_OFS = 8'h28;
   localparam logic [7:0] CTRL_SRC_LO_OFS = 8'h50;
   localparam logic [7:0] CTRL_SRC_HI_OFS = 8'h54;
   localparam logic [7:0] STATUS_OFS = 8'h58;

   // cell configuration fields
   localparam int unsigned LUT_MASK_LSB = 0;
   localparam int unsigned FF_TYPE_LSB = 16;
   localparam int unsigned CLK_SEL_BIT = 18;
   localparam int unsigned CLR_SEL_BIT = 19;
   localparam int unsigned OUT_SEL_LSB = 20;
   localparam int unsigned PACK_BIT = 23;
   localparam int unsigned LUT_CHAIN_BIT = 24;
   localparam int unsigned REG_CHAIN_BIT = 25;
   localparam int unsigned ARITH_BIT = 26;

   // control source high word fields
   localparam int unsigned FALL_LSB = 8;
   localparam int unsigned DEV_RST_EN_BIT = 10;
   localparam int unsigned USE_LSB = 11;

   // reset values
   localparam logic [CFG_W-1:0] CELL_CFG_RST = 27'h0000000;
   localparam logic [4*SEL_W-1:0] CELL_SEL_RST = 24'h000000;
   localparam logic [31:0] CTRL_SRC_LO_RST = 32'h00000000;
   localparam logic [HI_W-1:0] CTRL_SRC_HI_RST = 21'h000000;

   // control index inside the control generator
   localparam int unsigned CTL_CLK_A = 0;
   localparam int unsigned CTL_CLK_B = 1;
   localparam int unsigned CTL_ENA_A = 2;
   localparam int unsigned CTL_ENA_B = 3;
   localparam int unsigned CTL_CLR_A = 4;
   localparam int unsigned CTL_CLR_B = 5;
   localparam int unsigned CTL_ALOAD = 6;
   localparam int unsigned CTL_SCLR = 7;
   localparam int unsigned CTL_SLOAD = 8;
   localparam int unsigned CTL_ADDSUB = 9;

   typedef enum logic [1:0] {
      LCC_FF_D = 2'h0,
      LCC_FF_T = 2'h1,
      LCC_FF_JK = 2'h2,
      LCC_FF_SR = 2'h3
   } lcc_ff_t;

endpackage : lcc_pkg

// File: lcc_chk.sv
`timescale 1ns/1ns
module lcc_chk (
   // clock, reset and bus
   input wire logic CLK_SYS_I,
   input wire logic RST_B_I,
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   input wire logic [31:0] AVS_READDATA_O,
   input wire logic AVS_WAITREQUEST_O,
   // fabric
   input wire logic DEVICE_WIDE_RESET_N_I,
   input wire logic [9:0] CELL_ROUTE_A_O,
   input wire logic REG_CHAIN_O
);
   logic dev_en;
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_B_I);
   // shadow of the device reset enable bit
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_B_I) begin
         dev_en <= 1'b0;
      end else if (AVS_WRITE_I && !AVS_WAITREQUEST_O
                   && AVS_ADDRESS_I[7:2] == 6'h15
                   && AVS_BYTEENABLE_I[1]) begin
         dev_en <= AVS_WRITEDATA_I[10];
      end
   end
   sequence s_taken;
      (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
   endsequence
   sequence s_dev_hold;
      (dev_en && !DEVICE_WIDE_RESET_N_I)[*4];
   endsequence
   AST_ANSWER_NEXT: assert property (s_taken |=> !AVS_WAITREQUEST_O)
      else $error("request not answered next cycle");
   AST_ANSWER_ONE: assert property ($fell(AVS_WAITREQUEST_O)
      |=> AVS_WAITREQUEST_O) else $error("answer longer than one cycle");
   AST_ANSWER_CAUSE: assert property (!AVS_WAITREQUEST_O
      |-> $past(AVS_READ_I) || $past(AVS_WRITE_I))
      else $error("answer without request");
   AST_RDATA_HOLD: assert property ($changed(AVS_READDATA_O)
      |-> !AVS_WAITREQUEST_O && $past(AVS_READ_I))
      else $error("read data moved outside a read answer");
   AST_RST_CLEAN: assert property ($rose(RST_B_I) |-> AVS_WAITREQUEST_O
      && AVS_READDATA_O == 32'h0 && CELL_ROUTE_A_O == 10'h0)
      else $error("outputs not clear after reset");
   AST_DEV_RESET: assert property (s_dev_hold |=> !REG_CHAIN_O)
      else $error("device reset did not clear register");
   AST_RD_UNMAPPED: assert property (AVS_READ_I && AVS_WAITREQUEST_O
      && AVS_ADDRESS_I[7:2] > 6'h16 |=> AVS_READDATA_O == 32'h0)
      else $error("unmapped read not zero");
   AST_RD_WIDTH: assert property (AVS_READ_I && AVS_WAITREQUEST_O
      && AVS_ADDRESS_I[7:2] < 6'h0a |=> AVS_READDATA_O[31:27] == 5'h0)
      else $error("cell config upper bits not zero");
endmodule : lcc_chk
bind lcc_cluster lcc_chk chk_u (.CLK_SYS_I, .RST_B_I, .AVS_ADDRESS_I,
   .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I,
   .AVS_READDATA_O, .AVS_WAITREQUEST_O, .DEVICE_WIDE_RESET_N_I,
   .CELL_ROUTE_A_O, .REG_CHAIN_O);

// File: lcc_fabric.sv
`timescale 1ns/1ns
module lcc_fabric (
   // clock and requested levels
   input wire logic clk_i,
   input wire logic [51:0] req_i,
   // fabric lines
   output logic [51:0] pins_o
);
   initial pins_o = 52'h0;
   // routing lines settle one system cycle after the request
   always @(posedge clk_i) begin
      pins_o <= req_i;
   end
endmodule : lcc_fabric

// File: lcc_cluster_tb.sv
`timescale 1ns/1ns
module lcc_cluster_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic dev_n = 1'b1;
   logic [51:0] req = 52'h0;
   logic [51:0] f = 52'h0;
   logic [51:0] pins;
   logic [31:0] rdata, rs, q;
   logic [9:0] oa, ob, ol, ra, rb;
   logic lch, rch, cout, wait_r, ws;
   logic [32:0] os;
   logic [15:0] m;
   logic [10:0] s;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   int seed = 60291;
   int i;
   always #25 clk = ~clk;
   // settled copies, taken away from the sampling edge
   always @(negedge clk) begin
      ws = wait_r;
      rs = rdata;
      os = {cout, rch, lch, ol, ob, oa};
   end
   lcc_cluster dut_u (.CLK_SYS_I(clk), .RST_B_I(rst_b),
      .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_r),
      .ROW_CLOCK_I(pins[7:0]), .LOCAL_CTRL_I(pins[15:8]),
      .DIRECT_LINK_I(pins[35:16]), .ROUTE_I(pins[51:36]),
      .DEVICE_WIDE_RESET_N_I(dev_n), .CELL_ROUTE_A_O(oa),
      .CELL_ROUTE_B_O(ob), .CELL_LOCAL_O(ol), .LUT_CHAIN_O(lch),
      .REG_CHAIN_O(rch), .CARRY_OUT_O(cout));
   lcc_fabric fab_u (.clk_i(clk), .req_i(req), .pins_o(pins));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      do @(posedge clk); while (ws !== 1'b0);
      q = rs;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic fab(input logic [51:0] v);
      req <= v;
      repeat (6) @(posedge clk);
   endtask : fab
   // rising then falling edge on row clock 0
   task automatic pulse();
      f[0] = 1'b1;
      fab(f);
      f[0] = 1'b0;
      fab(f);
   endtask : pulse
   function automatic logic [10:0] arith(input logic [9:0] a, b,
                                         input logic sub);
      return {1'b0, a} + {1'b0, b ^ {10{sub}}} + {10'h0, sub};
   endfunction : arith
   task automatic report_and_stop();
      if (n_errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      bus(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 8'h54, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, 8'h24, 32'hffffffff);
      bus(1'b0, 8'h24, 32'h0);
      chk(q, 32'h07ffffff);
      bus(1'b0, 8'h5c, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, 8'h24, 32'h0);
      // random four-input tables on cell 0, inputs from routing
      bus(1'b1, 8'h28, {8'h0, 6'd33, 6'd32, 6'd31, 6'd30});
      for (i = 0; i < 12; i++) begin
         m = (i == 0) ? 16'h8000 : 16'($random(seed));
         f[51:36] = 16'($random(seed));
         bus(1'b1, 8'h00, {16'h0, m});
         fab(f);
         chk({os[20], os[10], os[0]}, {3{m[f[39:36]]}});
      end
      bus(1'b1, 8'h50, 32'h090a0800);
      bus(1'b1, 8'h54, 32'h0002a800);
      bus(1'b1, 8'h00, 32'h0010aaaa);
      f = 52'h0;
      f[8] = 1'b1;
      f[36] = 1'b1;
      fab(f);
      pulse();
      chk({os[10], os[0]}, 2'b11);
      f[8] = 1'b0;
      f[36] = 1'b0;
      pulse();
      chk({os[10], os[0]}, 2'b01);
      f[8] = 1'b1;
      f[36] = 1'b1;
      // flip-flop kinds T, D, T, JK, T, SR alternate the register
      for (i = 0; i < 6; i++) begin
         bus(1'b1, 8'h00, {14'h0004, 2'(12'hd91 >> (2 * i)), 16'haaaa});
         pulse();
         chk(os[0], i[0]);
      end
      f[8] = 1'b0;
      f[39] = 1'b1;
      f[9] = 1'b1;
      fab(f);
      bus(1'b0, 8'h58, 32'h0);
      // load is cluster-wide; cells 1-9 take cell 0 local out as d
      chk(q, 32'h000003ff);
      f[39] = 1'b0;
      fab(f);
      chk(os[0], 1'b0);
      f[39] = 1'b1;
      f[10] = 1'b1;
      fab(f);
      chk(os[0], 1'b0);
      f[10] = 1'b0;
      fab(f);
      chk(os[0], 1'b1);
      bus(1'b1, 8'h54, 32'h0002ac00);
      dev_n <= 1'b0;
      fab(f);
      chk(os[0], 1'b0);
      dev_n <= 1'b1;
      // ten-bit add and subtract across all cells
      bus(1'b1, 8'h54, 32'h001000b0);
      for (i = 0; i < 10; i++) begin
         bus(1'b1, 8'(4 * i), 32'h04000000);
         bus(1'b1, 8'(40 + 4 * i), {20'h0, 6'(20 + i), 6'(10 + i)});
      end
      for (i = 0; i < 10; i++) begin
         {rb, ra} = (i == 0) ? 20'hfffff :
                    (i == 1) ? 20'h00400 : 20'($random(seed));
         f = 52'h0;
         f[35:16] = {rb, ra};
         f[11] = i[0];
         fab(f);
         s = arith(ra, rb, i[0]);
         chk({os[32], os[9:0]}, s);
         chk(os[30], s[9]);
      end
      // shift chain clocked on falling edges, cell 9 packs its register
      bus(1'b1, 8'h54, 32'h0000a900);
      bus(1'b1, 8'h28, 32'h0000001e);
      for (i = 0; i < 10; i++) begin
         bus(1'b1, 8'(4 * i), (i == 0) ? 32'h0010aaaa :
             (i == 9) ? 32'h0290cccc : 32'h02100000);
      end
      f = 52'h0;
      f[8] = 1'b1;
      f[10] = 1'b1;
      fab(f);
      f[10] = 1'b0;
      ra = 10'h0;
      for (i = 0; i < 12; i++) begin
         f[36] = (i == 0) ? 1'b1 : 1'($random(seed));
         f[0] = 1'b1;
         fab(f);
         chk(os[9:0], ra);
         f[0] = 1'b0;
         fab(f);
         ra = {ra[8:0], f[36]};
         chk(os[9:0], ra);
         chk({os[31], os[19]}, {2{ra[9]}});
      end
      report_and_stop();
   end
endmodule : lcc_cluster_tb
